// ==== design/mpsbs_pkg.sv ====
// package: constants and carrier types for the parameter store and block sync
// Functional notes
// - keep 256 parameter slots, indices 0 to 255, each 32 bits wide.
// - parameter used as operand still range-checked; out of range raises error.
// - captures go to slots 224-226 servo1, 232-234 servo2, 240-241 aux3.
// - capture writes may overwrite special slots at any time.
// - all parameters clear to zero on reset and on new configuration store.
// - writes come from program load, host immediate load, host bulk request.
// - any parameter write fully replaces the old value.
// - program jump discards pre-processed operand and re-reads current value.
// - parameter operands allowed for rate, speed, dwell, positioning, continuous steps.
// - sync block holds idle axis until other axis finishes, then both start.
// - axis arriving after continuous move starts next move without stopping.
// - continuous move reaching sync early continues and reports block-sync error.
// - stopping positioning move before sync brings axis to rest and waits.
package mpsbs_pkg;
	// ===========================================================
	// memory geometry
	localparam int          PARAM_COUNT = 256;
	localparam int          IDX_W       = 8;
	localparam int          DATA_W      = 32;
	localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
	// ===========================================================
	// special slots
	localparam logic [7:0] SLOT_S1_STROBE1 = 8'he0;
	localparam logic [7:0] SLOT_S1_STROBE2 = 8'he1;
	localparam logic [7:0] SLOT_S1_FOLLOW  = 8'he2;
	localparam logic [7:0] SLOT_S2_STROBE1 = 8'he8;
	localparam logic [7:0] SLOT_S2_STROBE2 = 8'he9;
	localparam logic [7:0] SLOT_S2_FOLLOW  = 8'hea;
	localparam logic [7:0] SLOT_A3_STROBE1 = 8'hf0;
	localparam logic [7:0] SLOT_A3_STROBE2 = 8'hf1;
	// ===========================================================
	// step kinds; all but MPSBS_OTHER_STEP may take a parameter operand
	typedef enum logic [2:0] {
		MPSBS_RATE_CHANGE_SET_STEP  = 3'h0,
		MPSBS_SPEED_SET_STEP        = 3'h1,
		MPSBS_DWELL_STEP            = 3'h2,
		MPSBS_POSITIONING_MOVE_STEP = 3'h3,
		MPSBS_CONTINUOUS_MOVE_STEP  = 3'h4,
		MPSBS_OTHER_STEP            = 3'h7
	} mpsbs_step_t;
	// write request carrier
	typedef struct packed {
		logic        valid;
		logic [7:0]  index;
		logic [31:0] data;
	} mpsbs_wr_t;
	// capture event carrier: one bit per special slot
	typedef struct packed {
		logic [31:0] s1_pos;
		logic [31:0] s1_cmd;
		logic [31:0] s2_pos;
		logic [31:0] s2_cmd;
		logic [31:0] a3_pos;
		logic        s1_strobe1;
		logic        s1_strobe2;
		logic        s1_follow;
		logic        s2_strobe1;
		logic        s2_strobe2;
		logic        s2_follow;
		logic        a3_strobe1;
		logic        a3_strobe2;
	} mpsbs_capture_t;
	// operand fetch request
	typedef struct packed {
		logic        valid;
		mpsbs_step_t step;
		logic [7:0]  index;
		logic [31:0] lo_limit;
		logic [31:0] hi_limit;
	} mpsbs_opreq_t;
endpackage

// ==== design/mpsbs_top.sv ====
// parameter store, operand fetch and two-axis block sync
`timescale 1ns/1ps
`default_nettype none
module mpsbs_top (
	input  wire logic                      CLOCK_I,
	input  wire logic                      RST_N_I,
	input  wire logic                      CONFIG_STORE_I,
	input  wire mpsbs_pkg::mpsbs_wr_t      PROG_LOAD_I,
	input  wire mpsbs_pkg::mpsbs_wr_t      HOST_IMMEDIATE_I,
	input  wire mpsbs_pkg::mpsbs_wr_t      HOST_BULK_REQUEST_I,
	input  wire mpsbs_pkg::mpsbs_capture_t CAPTURE_I,
	input  wire mpsbs_pkg::mpsbs_opreq_t   OPREQ_I,
	input  wire logic                      JUMP_I,
	input  wire logic [1:0]                AXIS_AT_SYNC_I,
	input  wire logic [1:0]                AXIS_CONTINUOUS_I,
	input  wire logic [1:0]                AXIS_MOVE_DONE_I,
	output logic                           OPERAND_VALID_O,
	output logic [31:0]                    OPERAND_DATA_O,
	output logic                           OPERAND_RANGE_ERR_O,
	output logic                           OPERAND_STALE_O,
	output logic [1:0]                     AXIS_HOLD_O,
	output logic [1:0]                     AXIS_START_O,
	output logic [1:0]                     SYNC_ERR_O
);
	import mpsbs_pkg::*;

	// ===========================================================
	// parameter storage
	logic [31:0] param_reg [PARAM_COUNT];
	logic [1:0]  sync_err_reg;
	logic [1:0]  hold_reg;
	logic        op_valid_reg;
	logic [31:0] op_data_reg;
	logic        op_err_reg;
	logic        op_stale_reg;
	logic        op_ok;
	logic        op_fetch;
	logic [31:0] op_word;
	logic        op_below;
	logic        op_above;
	logic [1:0]  axis_arrived;
	logic [1:0]  axis_early;

	// write enable vectors, one per source; capture may set several bits at once, the others are one-hot
	logic [PARAM_COUNT-1:0] cap_we;
	logic [PARAM_COUNT-1:0] bulk_we;
	logic [PARAM_COUNT-1:0] imm_we;
	logic [PARAM_COUNT-1:0] prog_we;

	// ===========================================================
	// write decode
	// capture strobes land on their fixed slots
	always_comb begin
		cap_we                  = '0;
		cap_we[SLOT_S1_STROBE1] = CAPTURE_I.s1_strobe1;
		cap_we[SLOT_S1_STROBE2] = CAPTURE_I.s1_strobe2;
		cap_we[SLOT_S1_FOLLOW]  = CAPTURE_I.s1_follow;
		cap_we[SLOT_S2_STROBE1] = CAPTURE_I.s2_strobe1;
		cap_we[SLOT_S2_STROBE2] = CAPTURE_I.s2_strobe2;
		cap_we[SLOT_S2_FOLLOW]  = CAPTURE_I.s2_follow;
		cap_we[SLOT_A3_STROBE1] = CAPTURE_I.a3_strobe1;
		cap_we[SLOT_A3_STROBE2] = CAPTURE_I.a3_strobe2;
	end

	// host and program indices turned into one-hot enables
	always_comb begin
		bulk_we                            = '0;
		imm_we                             = '0;
		prog_we                            = '0;
		bulk_we[HOST_BULK_REQUEST_I.index] = HOST_BULK_REQUEST_I.valid;
		imm_we[HOST_IMMEDIATE_I.index]     = HOST_IMMEDIATE_I.valid;
		prog_we[PROG_LOAD_I.index]         = PROG_LOAD_I.valid;
	end

	// capture data: strobe slots take the axis position, follow slots the command
	function automatic logic [31:0] cap_val(input mpsbs_capture_t c, input logic [7:0] i);
		if (i == SLOT_S1_STROBE1 || i == SLOT_S1_STROBE2) begin
			cap_val = c.s1_pos;
		end else if (i == SLOT_S1_FOLLOW) begin
			cap_val = c.s1_cmd;
		end else if (i == SLOT_S2_STROBE1 || i == SLOT_S2_STROBE2) begin
			cap_val = c.s2_pos;
		end else if (i == SLOT_S2_FOLLOW) begin
			cap_val = c.s2_cmd;
		end else begin
			cap_val = c.a3_pos;
		end
	endfunction

	// slot update: reset/config clear, then capture, bulk, immediate, program
	always_ff @(posedge CLOCK_I) begin
		for (int i = 0; i < PARAM_COUNT; i++) begin
			if (!RST_N_I || CONFIG_STORE_I) begin
				param_reg[i] <= PARAM_RESET;
			end else if (cap_we[i]) begin
				param_reg[i] <= cap_val(CAPTURE_I, IDX_W'(i));
			end else if (bulk_we[i]) begin
				param_reg[i] <= HOST_BULK_REQUEST_I.data;
			end else if (imm_we[i]) begin
				param_reg[i] <= HOST_IMMEDIATE_I.data;
			end else if (prog_we[i]) begin
				param_reg[i] <= PROG_LOAD_I.data;
			end
		end
	end

	// ===========================================================
	// operand fetch with range check
	always_comb begin
		op_ok = (OPREQ_I.step == MPSBS_RATE_CHANGE_SET_STEP) ||
			(OPREQ_I.step == MPSBS_SPEED_SET_STEP) ||
			(OPREQ_I.step == MPSBS_DWELL_STEP) ||
			(OPREQ_I.step == MPSBS_POSITIONING_MOVE_STEP) ||
			(OPREQ_I.step == MPSBS_CONTINUOUS_MOVE_STEP);
	end

	// accepted fetch and the limit test of the addressed slot
	always_comb begin
		op_fetch = OPREQ_I.valid && op_ok;
		op_word  = param_reg[OPREQ_I.index];
		op_below = $signed(op_word) < $signed(OPREQ_I.lo_limit);
		op_above = $signed(op_word) > $signed(OPREQ_I.hi_limit);
	end

	// answer strobe: one cycle after an accepted fetch
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			op_valid_reg <= 1'b0;
		end else begin
			op_valid_reg <= op_fetch;
		end
	end

	// operand word: held until the next accepted fetch
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			op_data_reg <= PARAM_RESET;
		end else if (op_fetch) begin
			op_data_reg <= op_word;
		end
	end

	// range flag: only raised alongside the answer strobe
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			op_err_reg <= 1'b0;
		end else if (op_fetch) begin
			op_err_reg <= op_below || op_above;
		end else begin
			op_err_reg <= 1'b0;
		end
	end

	// jump flags the held operand stale so the step re-fetches fresh values
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			op_stale_reg <= 1'b0;
		end else if (JUMP_I) begin
			op_stale_reg <= 1'b1;
		end else if (OPREQ_I.valid && op_ok) begin
			op_stale_reg <= 1'b0;
		end
	end

	// ===========================================================
	// block sync: hold a stopped axis, start both together
	always_ff @(posedge CLOCK_I) begin
		for (int a = 0; a < 2; a++) begin
			if (!RST_N_I) begin
				hold_reg[a] <= 1'b0;
			end else if (AXIS_START_O[a]) begin
				hold_reg[a] <= 1'b0;
			end else if (AXIS_AT_SYNC_I[a] && !AXIS_CONTINUOUS_I[a]) begin
				hold_reg[a] <= 1'b1;
			end
		end
	end

	// an axis counts as arrived while at sync or already held
	assign axis_arrived = hold_reg | AXIS_AT_SYNC_I;

	// continuous arrival with the other axis not yet there
	always_comb begin
		for (int a = 0; a < 2; a++) begin
			axis_early[a] = AXIS_AT_SYNC_I[a] && AXIS_CONTINUOUS_I[a] &&
				!axis_arrived[1-a];
		end
	end

	// start when both arrived or the other axis's move is done; continuous axis never held
	always_comb begin
		for (int a = 0; a < 2; a++) begin
			AXIS_START_O[a] = axis_arrived[a] &&
				(axis_arrived[1-a] || AXIS_MOVE_DONE_I[1-a]);
			if (AXIS_AT_SYNC_I[a] && AXIS_CONTINUOUS_I[a]) begin
				AXIS_START_O[a] = 1'b1;
			end
		end
	end

	// sticky error on early continuous arrival; a new arrival beats a config clear
	always_ff @(posedge CLOCK_I) begin
		for (int a = 0; a < 2; a++) begin
			if (!RST_N_I) begin
				sync_err_reg[a] <= 1'b0;
			end else if (axis_early[a]) begin
				sync_err_reg[a] <= 1'b1;
			end else if (CONFIG_STORE_I) begin
				sync_err_reg[a] <= 1'b0;
			end
		end
	end

	// registered outputs straight from their flops
	assign OPERAND_VALID_O     = op_valid_reg;
	assign OPERAND_DATA_O      = op_data_reg;
	assign OPERAND_RANGE_ERR_O = op_err_reg;
	assign OPERAND_STALE_O     = op_stale_reg;
	assign AXIS_HOLD_O         = hold_reg;
	assign SYNC_ERR_O          = sync_err_reg;
endmodule
`default_nettype wire

// ==== verif/mpsbs_chk.sv ====
// checker: operand, hold and sync error relations at the top ports
`timescale 1ns/1ps
`default_nettype none
module mpsbs_chk (
	input wire logic                    CLOCK_I,
	input wire logic                    RST_N_I,
	input wire logic                    CONFIG_STORE_I,
	input wire mpsbs_pkg::mpsbs_opreq_t OPREQ_I,
	input wire logic                    JUMP_I,
	input wire logic [1:0]              AXIS_AT_SYNC_I,
	input wire logic [1:0]              AXIS_CONTINUOUS_I,
	input wire logic [1:0]              AXIS_MOVE_DONE_I,
	input wire logic                    OPERAND_VALID_O,
	input wire logic [31:0]             OPERAND_DATA_O,
	input wire logic                    OPERAND_RANGE_ERR_O,
	input wire logic                    OPERAND_STALE_O,
	input wire logic [1:0]              AXIS_HOLD_O,
	input wire logic [1:0]              AXIS_START_O,
	input wire logic [1:0]              SYNC_ERR_O
);
	import mpsbs_pkg::*;
	// ==========================================
	// steps of a fetch and of a sync arrival
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);
	sequence s_fetch; OPREQ_I.valid && OPREQ_I.step <= 3'h4; endsequence
	sequence s_wait0; AXIS_AT_SYNC_I == 2'h1 && !AXIS_CONTINUOUS_I[0] && AXIS_MOVE_DONE_I == 2'h0
		&& !AXIS_HOLD_O[1];
	endsequence
	sequence s_early0; AXIS_AT_SYNC_I == 2'h1 && AXIS_CONTINUOUS_I[0] && !AXIS_HOLD_O[1];
	endsequence
	a_fetch_answers: assert property (s_fetch |=> OPERAND_VALID_O)
		else $error("operand fetch not answered");
	a_bad_step_quiet: assert property (!(OPREQ_I.valid && OPREQ_I.step <= 3'h4) |=> !OPERAND_VALID_O)
		else $error("operand answered without a legal fetch");
	a_range_err_exact: assert property (s_fetch |=> OPERAND_RANGE_ERR_O == (
		$signed(OPERAND_DATA_O) < $signed($past(OPREQ_I.lo_limit)) ||
		$signed(OPERAND_DATA_O) > $signed($past(OPREQ_I.hi_limit)))) else $error("range flag wrong");
	a_err_with_valid: assert property (OPERAND_RANGE_ERR_O |-> OPERAND_VALID_O)
		else $error("range flag outside an answer");
	a_jump_sets_stale: assert property (JUMP_I && !OPREQ_I.valid |=> OPERAND_STALE_O)
		else $error("jump did not mark operand stale");
	a_idle_axis_held: assert property (s_wait0 |=> AXIS_HOLD_O[0])
		else $error("waiting axis not held");
	a_start_frees_hold: assert property (AXIS_START_O == 2'h3 |=> AXIS_HOLD_O == 2'h0)
		else $error("hold kept after joint start");
	a_early_flags_err: assert property (s_early0 |=> SYNC_ERR_O[0] && !AXIS_HOLD_O[0])
		else $error("early continuous arrival not flagged");
	a_err_sticky: assert property (SYNC_ERR_O[0] && !CONFIG_STORE_I |=> SYNC_ERR_O[0])
		else $error("sync error lost");
	a_config_clears: assert property (CONFIG_STORE_I && (AXIS_AT_SYNC_I & AXIS_CONTINUOUS_I) == 2'h0
		|=> SYNC_ERR_O == 2'h0)
		else $error("config store left sync error");
endmodule
bind mpsbs_top mpsbs_chk mpsbs_chk_inst (.*);
`default_nettype wire

// ==== verif/mpsbs_host.sv ====
// host model: immediate and bulk parameter writes
`timescale 1ns/1ps
`default_nettype none
module mpsbs_host (
	input  wire logic                go_i,
	input  wire logic                bulk_i,
	input  wire logic [7:0]          idx_i,
	input  wire logic [31:0]         dat_i,
	output var mpsbs_pkg::mpsbs_wr_t imm_o,
	output var mpsbs_pkg::mpsbs_wr_t blk_o
);
	import mpsbs_pkg::*;
	// ==========================================
	// one request per pulse; an idle bus shows inverted data
	assign imm_o = '{go_i && !bulk_i, idx_i, (go_i && !bulk_i) ? dat_i : ~dat_i};
	assign blk_o = '{go_i && bulk_i, idx_i, (go_i && bulk_i) ? dat_i : ~dat_i};
endmodule
`default_nettype wire

// ==== verif/test_mpsbs_top.sv ====
// testbench: parameter store, operand fetch and block sync
`timescale 1ns/1ps
`default_nettype none
module test_mpsbs_top;
	import mpsbs_pkg::*;
	// ==========================================
	// stimulus, expectation queue and counters
	logic clk = 0, rst_n = 0, cfg = 0, jump = 0, go = 0, bulk = 0, v, er, st;
	logic [7:0] idx = '0, i;
	logic [31:0] dat = '0, d, od, mem [256];
	logic [1:0] at = '0, cont = '0, done = '0, hold, start, serr;
	mpsbs_wr_t prog = '0, imm, blk;
	mpsbs_capture_t cap = '0;
	mpsbs_opreq_t req = '0;
	logic [32:0] q [$];
	int fails = 0, tests_run = 0, seed = 30;
	always #2.5 clk = ~clk;
	mpsbs_host mpsbs_host_inst (.go_i(go), .bulk_i(bulk), .idx_i(idx), .dat_i(dat),
		.imm_o(imm), .blk_o(blk));
	mpsbs_top mpsbs_top_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .CONFIG_STORE_I(cfg),
		.PROG_LOAD_I(prog), .HOST_IMMEDIATE_I(imm), .HOST_BULK_REQUEST_I(blk), .CAPTURE_I(cap),
		.OPREQ_I(req), .JUMP_I(jump), .AXIS_AT_SYNC_I(at), .AXIS_CONTINUOUS_I(cont),
		.AXIS_MOVE_DONE_I(done), .OPERAND_VALID_O(v), .OPERAND_DATA_O(od),
		.OPERAND_RANGE_ERR_O(er), .OPERAND_STALE_O(st), .AXIS_HOLD_O(hold),
		.AXIS_START_O(start), .SYNC_ERR_O(serr));
	task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// source 0 program, 1 immediate, 2 bulk
	task automatic put(input int s, input logic [7:0] a, input logic [31:0] x);
		@(posedge clk);
		if (s == 0) prog <= '{1'b1, a, x};
		else begin
			go <= 1'b1;
			bulk <= (s == 2);
			idx <= a;
			dat <= x;
		end
		mem[a] = x;
		@(posedge clk);
		prog.valid <= 1'b0;
		go <= 1'b0;
	endtask
	task automatic get(input mpsbs_step_t s, input logic [7:0] a, input logic [31:0] lo, hi);
		@(posedge clk);
		req <= '{1'b1, s, a, lo, hi};
		if (s <= 3'h4) q.push_back({$signed(mem[a]) < $signed(lo) || $signed(mem[a]) > $signed(hi), mem[a]});
		@(posedge clk);
		req.valid <= 1'b0;
	endtask
	// strobe b of eight, each source word distinct, optionally with a clashing bulk write
	task automatic grab(input int b, input logic [31:0] x, input logic clash);
		@(posedge clk);
		i = 8'(b < 3 ? 224 + b : b < 6 ? 229 + b : 234 + b);
		cap <= {x, ~x, x + 32'h1, ~x + 32'h1, x + 32'h2, 8'h80 >> b};
		go <= clash;
		bulk <= 1'b1;
		idx <= i;
		dat <= ~x;
		mem[i] = b == 2 ? ~x : b == 5 ? ~x + 32'h1 : b < 2 ? x : b < 5 ? x + 32'h1 : x + 32'h2;
		@(posedge clk);
		cap <= {{5{~x}}, 8'h00};
		go <= 1'b0;
	endtask
	// answers are checked in order against the queue
	always @(negedge clk) if (v === 1'b1) begin
		if (q.size() == 0) chk("extra operand", '0, {1'b1, od});
		else chk("operand", q.pop_front(), {er, od});
	end
	initial begin
		#20000;
		fails++;
		close_out();
	end
	initial begin
		foreach (mem[k]) mem[k] = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		get(MPSBS_DWELL_STEP, 8'hff, 32'h0, 32'h0);
		for (int k = 0; k < 15; k++) begin
			d = $random(seed);
			i = k < 3 ? 8'h00 : k < 6 ? 8'hff : 8'($random(seed));
			put(k % 3, i, ~d);
			put((k + 1) % 3, i, d);
			get(mpsbs_step_t'(k % 5), i, d - 32'h1, k[0] ? d : d - 32'h1);
		end
		get(MPSBS_OTHER_STEP, i, 32'h0, 32'h0);
		$display("test writes done");
		for (int k = 0; k < 9; k++) begin
			grab(k % 8, $random(seed), k == 8);
			get(MPSBS_POSITIONING_MOVE_STEP, i, 32'h8000_0000, 32'h7fff_ffff);
		end
		$display("test captures done");
		@(posedge clk) jump <= 1'b1;
		@(posedge clk) jump <= 1'b0;
		@(negedge clk) chk("stale", 1, st);
		get(MPSBS_SPEED_SET_STEP, i, 32'h0, 32'h0);
		@(negedge clk) chk("stale", 0, st);
		@(posedge clk) at <= 2'h1;
		repeat (2) @(posedge clk);
		@(negedge clk) chk("hold", 2'h1, hold);
		@(posedge clk) at <= 2'h3;
		done <= 2'h2;
		@(negedge clk) chk("start", 2'h3, start);
		@(posedge clk) at <= 2'h0;
		done <= 2'h0;
		@(negedge clk) chk("hold", 2'h0, hold);
		@(posedge clk) at <= 2'h1;
		cont <= 2'h1;
		@(negedge clk) chk("start", 2'h1, start);
		@(posedge clk) at <= 2'h0;
		cont <= 2'h0;
		@(negedge clk) chk("sync err", {2'h1, 2'h0}, {serr, hold});
		@(posedge clk) cfg <= 1'b1;
		@(posedge clk) cfg <= 1'b0;
		foreach (mem[k]) mem[k] = '0;
		@(negedge clk) chk("sync err", 2'h0, serr);
		get(MPSBS_CONTINUOUS_MOVE_STEP, i, 32'h0, 32'h0);
		$display("test sync and clear done");
		repeat (3) @(posedge clk);
		close_out();
	end
endmodule
`default_nettype wire
